// ===== src/gauge_pkg.sv
// Shared constants and types of the gauge pin signaling block
package gauge_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned PULSE_NS = 1000000;
   localparam int unsigned PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
   localparam int unsigned WAIT_STEP_NS = 5000;
   localparam int unsigned WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
   localparam logic [9:0] POLL_MS_LAST = 10'h3e7;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_TEMP_LIMITS = 8'h04;
   localparam logic [7:0] REG_SOC_CFG = 8'h08;
   localparam logic [7:0] REG_SHUTDOWN = 8'h0c;
   localparam logic [7:0] REG_FLASH_WAIT = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_TEMPERATURE = 8'h18;

   // ----------------------------------------------------------------
   // Config bit positions
   // ----------------------------------------------------------------
   localparam int unsigned CFG_TEMP_SRC = 0;
   localparam int unsigned CFG_LOWBAT_POL = 1;
   localparam int unsigned CFG_BATGOOD_POL = 2;
   localparam int unsigned CFG_SEL_LO = 3;
   localparam int unsigned CFG_SEL_HI = 4;
   localparam int unsigned CFG_REMOVAL_IRQ = 5;
   localparam int unsigned CFG_FIRST_OCV_IRQ = 6;
   localparam int unsigned CFG_RESTORE = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CONFIG_RESET = 8'h0b;
   localparam logic [23:0] LIMITS_RESET = 24'h022d00;
   localparam logic [23:0] SOC_CFG_RESET = 24'h0f0a00;
   localparam logic [31:0] SHUTDOWN_RESET = 32'h0c1c0bb8;
   localparam logic [15:0] FLASH_WAIT_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Levels
   // ----------------------------------------------------------------
   localparam logic [7:0] SOC_FULL = 8'h64;
   localparam logic [7:0] UPPER_NONE = 8'hff;
   localparam logic [11:0] THERM_OPEN_MV = 12'h992;

   typedef enum logic [1:0] {
      CS_RELAX = 2'h0,
      CS_CHARGE = 2'h1,
      CS_DISCHARGE = 2'h2
   } chg_state_t;

   typedef enum logic [1:0] {
      BG_NO_BATT = 2'h0,
      BG_WAIT_OCV = 2'h1,
      BG_GOOD = 2'h3,
      BG_INHIBIT = 2'h2
   } bg_state_t;

endpackage

// ===== src/pulse_if.sv
// Trigger and busy pair between the pin logic and a pulse timer
`timescale 1ns/1ps
`default_nettype none
interface pulse_if;
   logic trigger;
   logic busy;
   modport timer(input trigger, output busy);
   modport owner(output trigger, input busy);
endinterface
`default_nettype wire

// ===== src/tick_divider.sv
// Divider that emits a one-cycle enable every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 1000
) (
   input wire logic clk,
   input wire logic resetn,
   output logic tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } div_state_t;

   div_state_t st;
   div_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 32'(DIV - 1)) begin
         next_st.cnt = 32'h0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule // tick_divider
`default_nettype wire

// ===== src/pulse_timer.sv
// Retriggerable one-shot of a fixed number of clocks
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
   parameter int unsigned WIDTH = 200000
) (
   input wire logic clk,
   input wire logic resetn,
   pulse_if.timer port
);
   typedef struct packed {
      logic [31:0] cnt;
      logic busy;
   } pt_state_t;

   pt_state_t st;
   pt_state_t next_st;

   // Exact width: a count of clocks, restarted by a new trigger
   always_comb begin
      next_st = st;
      if (port.trigger) begin
         next_st.busy = 1'b1;
         next_st.cnt = 32'(WIDTH - 1);
      end else if (st.cnt != 32'h0) begin
         next_st.cnt = st.cnt - 32'h1;
      end else begin
         next_st.busy = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign port.busy = st.busy;

   a_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
      port.trigger |=> port.busy ##1 (port.busy || WIDTH < 2))
      else $error("pulse did not start on trigger");
endmodule // pulse_timer
`default_nettype wire

// ===== src/gauge_status_pin_signaling.sv
// Gauge status pins, interrupt pulses and temperature source select
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module gauge_status_pin_signaling #(
   parameter int unsigned ms_cycles = gauge_pkg::PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [7:0] relative_charge_level,
   input wire logic [15:0] battery_mv,
   input wire logic [1:0] charge_state,
   input wire logic [11:0] thermistor_input,
   input wire logic [7:0] thermistor_temp,
   input wire logic [7:0] internal_temp,
   input wire logic init_active,
   input wire logic ocv_busy,
   input wire logic ocv_done,
   input wire logic flash_update_req,
   input wire logic flash_update_busy,
   input wire logic factory_restore_busy,
   input wire logic battery_insert_in,
   output logic battery_insert_out,
   output logic battery_insert_oe,
   output logic low_battery_pin,
   output logic battery_good_pin,
   output logic charge_irq_pin,
   output logic flash_update_go,
   output logic thermistor_gauge_enable,
   output logic thermistor_charger_enable,
   output logic battery_present
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cfg;
      logic [23:0] tlim;
      logic [23:0] soccfg;
      logic [31:0] sdcfg;
      logic [15:0] fwait;
      logic waitreq;
      logic [31:0] rdata;
      gauge_pkg::bg_state_t bg;
      logic present;
      logic [9:0] poll_ms;
      logic l1_flag;
      logic [7:0] prev_soc;
      logic [15:0] prev_mv;
      logic [1:0] prev_chg;
      logic [7:0] lower;
      logic align;
      logic flash_wait;
      logic [15:0] flash_cnt;
      logic flash_go;
      logic trig;
      logic armed;
      logic irq;
      logic lowbat;
      logic batgood;
      logic gauge_en;
      logic charger_en;
      logic bi_out;
      logic bi_oe;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;

   logic ms_tick;
   logic step_tick;
   logic poll_now;
   logic [1:0] pin_function_code;
   logic [7:0] temp_now;
   logic [7:0] delta;
   logic [8:0] upper_sum;
   logic [7:0] upper;
   logic [8:0] low_in;
   logic [8:0] high_in;
   logic temp_out;
   logic temp_back;
   logic bg_asserted;
   logic wait_active;

   pulse_if irq_pulse ();

   tick_divider #(.DIV(ms_cycles)) ms_div (
      .clk(clk),
      .resetn(resetn),
      .tick(ms_tick)
   );

   tick_divider #(.DIV(gauge_pkg::WAIT_STEP_CYCLES)) step_div (
      .clk(clk),
      .resetn(resetn),
      .tick(step_tick)
   );

   pulse_timer #(.WIDTH(ms_cycles)) irq_timer (
      .clk(clk),
      .resetn(resetn),
      .port(irq_pulse.timer)
   );

   function automatic logic [31:0] merge_be(input logic [31:0] old,
         input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Decodes
   // ----------------------------------------------------------------
   always_comb begin
      // Unused pattern 1/1 falls back to the default code
      unique case ({st.cfg[gauge_pkg::CFG_SEL_HI],
            st.cfg[gauge_pkg::CFG_SEL_LO]})
         2'h0: pin_function_code = 2'h0;
         2'h2: pin_function_code = 2'h2;
         default: pin_function_code = 2'h1;
      endcase
   end

   assign temp_now = st.cfg[gauge_pkg::CFG_TEMP_SRC] ? thermistor_temp :
      internal_temp;
   assign delta = st.soccfg[7:0];
   assign upper_sum = {1'b0, st.lower} + {1'b0, delta};
   assign upper = (upper_sum > {1'b0, gauge_pkg::SOC_FULL}) ?
      gauge_pkg::UPPER_NONE : upper_sum[7:0];
   assign low_in = {1'b0, st.tlim[7:0]} + {1'b0, st.tlim[23:16]};
   assign high_in = {1'b0, st.tlim[15:8]} - {1'b0, st.tlim[23:16]};
   assign temp_out = temp_now < st.tlim[7:0] ||
      temp_now > st.tlim[15:8];
   assign temp_back = {1'b0, temp_now} >= low_in &&
      {1'b0, temp_now} <= high_in;
   assign poll_now = ms_tick && st.poll_ms == gauge_pkg::POLL_MS_LAST;
   assign bg_asserted = battery_good_pin ==
      st.cfg[gauge_pkg::CFG_BATGOOD_POL];
   assign wait_active = !init_active && st.fwait != 16'h0;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.trig = 1'b0;
      next_st.flash_go = 1'b0;
      next_st.prev_soc = relative_charge_level;
      next_st.prev_mv = battery_mv;
      next_st.prev_chg = charge_state;

      // Presence only sampled at the poll; pin is never driven
      if (ms_tick) begin
         next_st.poll_ms = poll_now ? 10'h0 : st.poll_ms + 10'h1;
      end
      if (poll_now) begin
         next_st.present = !battery_insert_in &&
            thermistor_input < gauge_pkg::THERM_OPEN_MV;
      end
      if (st.present && !next_st.present &&
            st.cfg[gauge_pkg::CFG_REMOVAL_IRQ]) begin
         next_st.trig = 1'b1;
      end

      // Battery good sequence
      case (st.bg)
         gauge_pkg::BG_NO_BATT: begin
            if (st.present) begin
               next_st.bg = gauge_pkg::BG_WAIT_OCV;
            end
         end
         gauge_pkg::BG_WAIT_OCV: begin
            if (ocv_done) begin
               next_st.bg = gauge_pkg::BG_GOOD;
            end
         end
         gauge_pkg::BG_GOOD: begin
            if (pin_function_code == 2'h1 && temp_out) begin
               next_st.bg = gauge_pkg::BG_INHIBIT;
            end
         end
         default: begin
            if (pin_function_code != 2'h1 || temp_back) begin
               next_st.bg = gauge_pkg::BG_GOOD;
            end
         end
      endcase
      if (!st.present) begin
         next_st.bg = gauge_pkg::BG_NO_BATT;
      end

      // Level 1 flag with its set and clear thresholds
      if (relative_charge_level <= st.soccfg[15:8]) begin
         next_st.l1_flag = 1'b1;
      end else if (relative_charge_level >= st.soccfg[23:16]) begin
         next_st.l1_flag = 1'b0;
      end
      // Crossing test, so a level that jumps past a threshold still pulses
      if ((relative_charge_level <= st.soccfg[15:8] &&
            st.prev_soc > st.soccfg[15:8]) ||
            (relative_charge_level >= st.soccfg[23:16] &&
            st.prev_soc < st.soccfg[23:16])) begin
         next_st.trig = 1'b1;
      end

      // Shutdown voltage thresholds, falling through the low one or rising through the high one
      if ((battery_mv <= st.sdcfg[15:0] && st.prev_mv > st.sdcfg[15:0]) ||
            (battery_mv >= st.sdcfg[31:16] &&
            st.prev_mv < st.sdcfg[31:16])) begin
         next_st.trig = 1'b1;
      end

      // Delta points: lower is the last point passed
      if (delta == 8'h0) begin
         next_st.lower = gauge_pkg::SOC_FULL;
         next_st.align = 1'b1;
      end else begin
         if (charge_state != st.prev_chg) begin
            next_st.trig = 1'b1;
         end
         if (st.align) begin
            // Walk down to the current level without pulsing
            if (relative_charge_level < st.lower) begin
               next_st.lower = st.lower >= delta ? st.lower - delta : 8'h0;
            end else begin
               next_st.align = 1'b0;
            end
         end else if (charge_state == gauge_pkg::CS_CHARGE &&
               upper != gauge_pkg::UPPER_NONE &&
               relative_charge_level >= upper) begin
            next_st.lower = upper;
            next_st.trig = 1'b1;
         end else if (charge_state == gauge_pkg::CS_DISCHARGE) begin
            if (relative_charge_level < st.lower) begin
               next_st.lower = st.lower >= delta ? st.lower - delta : 8'h0;
               next_st.trig = 1'b1;
            end
            if (relative_charge_level == 8'h0 && st.prev_soc != 8'h0) begin
               next_st.trig = 1'b1;
            end
         end
      end

      // Previous samples are not real yet in the first cycle after reset
      if (!st.armed) begin
         next_st.trig = 1'b0;
      end
      next_st.armed = 1'b1;

      // Flash update indication and wait in 5us steps
      if (st.flash_wait) begin
         if (step_tick) begin
            next_st.flash_cnt = st.flash_cnt - 16'h1;
            if (st.flash_cnt == 16'h1) begin
               next_st.flash_wait = 1'b0;
               next_st.flash_go = 1'b1;
            end
         end
      end else if (flash_update_req) begin
         if (wait_active) begin
            next_st.flash_wait = 1'b1;
            next_st.flash_cnt = st.fwait;
         end else begin
            next_st.flash_go = 1'b1;
         end
      end

      // Bus slave: one wait cycle, then the access completes
      next_st.waitreq = 1'b1;
      if (st.waitreq && (read || write)) begin
         next_st.waitreq = 1'b0;
      end
      if (st.waitreq && read) begin
         if (address == gauge_pkg::REG_CONFIG) begin
            next_st.rdata = {24'h0, st.cfg};
         end else if (address == gauge_pkg::REG_TEMP_LIMITS) begin
            next_st.rdata = {8'h0, st.tlim};
         end else if (address == gauge_pkg::REG_SOC_CFG) begin
            next_st.rdata = {8'h0, st.soccfg};
         end else if (address == gauge_pkg::REG_SHUTDOWN) begin
            next_st.rdata = st.sdcfg;
         end else if (address == gauge_pkg::REG_FLASH_WAIT) begin
            next_st.rdata = {16'h0, st.fwait};
         end else if (address == gauge_pkg::REG_STATUS) begin
            next_st.rdata = {24'h0, st.irq, st.flash_wait,
               pin_function_code, st.l1_flag,
               st.bg == gauge_pkg::BG_INHIBIT,
               st.bg == gauge_pkg::BG_GOOD, st.present};
         end else if (address == gauge_pkg::REG_TEMPERATURE) begin
            next_st.rdata = {24'h0, temp_now};
         end else begin
            next_st.rdata = 32'h0;
         end
      end
      if (!st.waitreq && write) begin
         if (address == gauge_pkg::REG_CONFIG) begin
            next_st.cfg = 8'(merge_be({24'h0, st.cfg}, writedata,
               byteenable));
            if (byteenable[0] && writedata[gauge_pkg::CFG_RESTORE]) begin
               next_st.cfg = gauge_pkg::CONFIG_RESET;
               next_st.tlim = gauge_pkg::LIMITS_RESET;
               next_st.soccfg = gauge_pkg::SOC_CFG_RESET;
               next_st.sdcfg = gauge_pkg::SHUTDOWN_RESET;
               next_st.fwait = gauge_pkg::FLASH_WAIT_RESET;
            end
            next_st.cfg[gauge_pkg::CFG_RESTORE] = 1'b0;
         end else if (address == gauge_pkg::REG_TEMP_LIMITS) begin
            next_st.tlim = 24'(merge_be({8'h0, st.tlim}, writedata,
               byteenable));
         end else if (address == gauge_pkg::REG_SOC_CFG) begin
            next_st.soccfg = 24'(merge_be({8'h0, st.soccfg}, writedata,
               byteenable));
            next_st.lower = gauge_pkg::SOC_FULL;
            next_st.align = 1'b1;
         end else if (address == gauge_pkg::REG_SHUTDOWN) begin
            next_st.sdcfg = merge_be(st.sdcfg, writedata, byteenable);
         end else if (address == gauge_pkg::REG_FLASH_WAIT) begin
            next_st.fwait = 16'(merge_be({16'h0, st.fwait}, writedata,
               byteenable));
         end
      end

      // Pins, all registered
      next_st.lowbat = st.cfg[gauge_pkg::CFG_LOWBAT_POL] ? next_st.l1_flag :
         !next_st.l1_flag;
      next_st.batgood = st.cfg[gauge_pkg::CFG_BATGOOD_POL] ~^
         (next_st.bg == gauge_pkg::BG_GOOD);
      next_st.gauge_en = st.cfg[gauge_pkg::CFG_TEMP_SRC] &&
         (pin_function_code == 2'h1 ||
         charge_state != gauge_pkg::CS_CHARGE);
      next_st.charger_en = pin_function_code == 2'h2 &&
         charge_state == gauge_pkg::CS_CHARGE;
      next_st.irq = irq_pulse.busy || factory_restore_busy ||
         (ocv_busy && (!init_active ||
         st.cfg[gauge_pkg::CFG_FIRST_OCV_IRQ])) ||
         st.flash_wait || (flash_update_busy && wait_active);
   end

   // Reset holds every control bit at its documented default
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.cfg <= gauge_pkg::CONFIG_RESET;
         st.tlim <= gauge_pkg::LIMITS_RESET;
         st.soccfg <= gauge_pkg::SOC_CFG_RESET;
         st.sdcfg <= gauge_pkg::SHUTDOWN_RESET;
         st.fwait <= gauge_pkg::FLASH_WAIT_RESET;
         st.waitreq <= 1'b1;
         st.bg <= gauge_pkg::BG_NO_BATT;
         st.lower <= gauge_pkg::SOC_FULL;
         st.align <= 1'b1;
         st.lowbat <= 1'b0;
         st.batgood <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign irq_pulse.trigger = st.trig;
   assign readdata = st.rdata;
   assign waitrequest = st.waitreq;
   assign battery_insert_out = st.bi_out;
   assign battery_insert_oe = st.bi_oe;
   assign low_battery_pin = st.lowbat;
   assign battery_good_pin = st.batgood;
   assign charge_irq_pin = st.irq;
   assign flash_update_go = st.flash_go;
   assign thermistor_gauge_enable = st.gauge_en;
   assign thermistor_charger_enable = st.charger_en;
   assign battery_present = st.present;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_removed;
      $fell(st.present) && st.cfg[gauge_pkg::CFG_REMOVAL_IRQ];
   endsequence

   a_ocv_irq_held: assert property (ocv_busy && !init_active
      |=> charge_irq_pin) else $error("no interrupt during OCV");
   a_restore_irq: assert property (factory_restore_busy
      |=> charge_irq_pin) else $error("no interrupt during restore");
   a_removal_pulse: assert property (s_removed
      |-> ##[1:3] charge_irq_pin) else $error("no removal pulse");
   a_state_change: assert property (delta != 8'h0 &&
      charge_state != st.prev_chg |-> ##[1:3] charge_irq_pin)
      else $error("no state change pulse");
   a_bg_after_ocv: assert property (
      $rose(st.bg == gauge_pkg::BG_GOOD) |->
      $past(ocv_done) || $past(st.bg) == gauge_pkg::BG_INHIBIT)
      else $error("battery good rose without OCV");
   a_inhibit_hot: assert property (st.bg == gauge_pkg::BG_GOOD &&
      pin_function_code == 2'h1 && temp_out |=> !bg_asserted)
      else $error("battery good kept out of limits");
   a_poll_only: assert property ($changed(st.present)
      |-> $past(poll_now)) else $error("presence changed off poll");
   a_flash_nowait: assert property (flash_update_req && !st.flash_wait
      && !wait_active |=> flash_update_go) else $error("flash go late");
   a_lowbat_follow: assert property (##1 $stable(st.cfg)
      |-> low_battery_pin == (st.l1_flag ~^
      st.cfg[gauge_pkg::CFG_LOWBAT_POL])) else $error("low pin wrong");
endmodule // gauge_status_pin_signaling
`default_nettype wire

// ===== test/pack_model.sv
// Battery pack and charger model at the gauge pins
`timescale 1ns/1ps
`default_nettype none
module pack_model (
   input wire logic inserted,
   input wire logic insert_out,
   input wire logic insert_oe,
   input wire logic good_pin,
   output logic insert_pin,
   output logic [11:0] therm_mv,
   output logic charging
);
   // Weak pull-up keeps the pin high with no pack fitted
   assign insert_pin = insert_oe ? insert_out : !inserted;
   // Open thermistor reads near 2.5V once the pack is gone
   assign therm_mv = inserted ? 12'h400 : gauge_pkg::THERM_OPEN_MV;
   // Charger runs only while good is low, the default polarity
   assign charging = inserted && good_pin == 1'b0;
endmodule // pack_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the gauge pin signaling block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int MS = 20;
   logic clk = 0, resetn = 0, read = 0, write = 0, ocv_done = 0;
   logic restore_busy = 0, ocv_busy = 0, inserted = 0;
   logic freq = 0, init = 0;
   wire logic fgo, gen, cen;
   logic [7:0] address = 8'h00, level = 8'h32, ttemp = 8'h19, itemp = 8'h23;
   logic [31:0] wdata = 32'h0, rd = 32'h0;
   logic [15:0] mv = 16'h0fa0;
   logic [1:0] cstate = 2'h0;
   wire logic waitreq, irq, lowbat, good, ins_out, ins_oe, ins_pin;
   wire logic charging, present;
   wire logic [11:0] therm;
   wire logic [31:0] rdata;
   int bad_count = 0, num_checks = 0, cycles = 0;
   always #2.5 clk = ~clk;
   gauge_status_pin_signaling #(.ms_cycles(MS)) dut_u (.clk(clk),
      .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(wdata), .byteenable(4'hf), .readdata(rdata),
      .waitrequest(waitreq), .relative_charge_level(level),
      .battery_mv(mv), .charge_state(cstate), .thermistor_input(therm),
      .thermistor_temp(ttemp), .internal_temp(itemp), .init_active(init),
      .ocv_busy(ocv_busy), .ocv_done(ocv_done), .flash_update_req(freq),
      .flash_update_busy(1'b0), .factory_restore_busy(restore_busy),
      .battery_insert_in(ins_pin), .battery_insert_out(ins_out),
      .battery_insert_oe(ins_oe), .low_battery_pin(lowbat),
      .battery_good_pin(good), .charge_irq_pin(irq),
      .flash_update_go(fgo), .thermistor_gauge_enable(gen),
      .thermistor_charger_enable(cen), .battery_present(present));
   pack_model pack_u (.inserted(inserted), .insert_out(ins_out),
      .insert_oe(ins_oe), .good_pin(good), .insert_pin(ins_pin),
      .therm_mv(therm), .charging(charging));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      address <= a;
      wdata <= d;
      {read, write} <= {!wr, wr};
      do @(posedge clk); while (waitreq !== 1'b0);
      rd = rdata;
      {read, write} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic pulse_len;
      int n = 0, w = 0;
      while (irq !== 1'b1 && w++ < 8) @(posedge clk);
      while (irq === 1'b1 && n++ < 99) @(posedge clk);
      chk(n, MS);
   endtask
   task automatic t_present;
      inserted <= 1'b1;
      while (present !== 1'b1 && cycles < 24000) @(posedge clk);
      chk(present, 1);
      chk(ins_oe, 0);
      chk(good, 1);
      ocv_done <= 1'b1;
      @(posedge clk);
      ocv_done <= 1'b0;
      repeat (3) @(posedge clk);
      chk(good, 0);
      chk(charging, 1);
      $display("presence done");
   endtask
   task automatic t_irq;
      mv <= 16'h0b00;
      pulse_len();
      bus(1, gauge_pkg::REG_SOC_CFG, 32'h000f0a0a);
      repeat (20) @(posedge clk);
      cstate <= 2'h1;
      pulse_len();
      level <= 8'h3c;
      pulse_len();
      for (int i = 1; i < 3; i++) begin
         {restore_busy, ocv_busy} <= i[1:0];
         repeat (3) @(posedge clk);
         chk(irq, 1);
      end
      {restore_busy, ocv_busy, init} <= 3'b011;
      repeat (3) @(posedge clk);
      chk(irq, 0);
      {ocv_busy, init} <= 2'b00;
      repeat (3) @(posedge clk);
      chk(irq, 0);
      $display("interrupt done");
   endtask
   task automatic t_cfg;
      bus(0, gauge_pkg::REG_CONFIG, 0);
      chk(rd, 32'h0b);
      bus(0, 8'h40, 0);
      chk(rd, 0);
      bus(0, gauge_pkg::REG_TEMPERATURE, 0);
      chk(rd, ttemp);
      for (int i = 0; i < 3; i++) begin
         bus(1, gauge_pkg::REG_CONFIG, 32'h1 | (i << 3));
         bus(0, gauge_pkg::REG_STATUS, 0);
         chk(rd[5:4], i);
         chk({gen, cen}, {i == 1, i == 2});
      end
      level <= 8'h05;
      pulse_len();
      chk(lowbat, 0);
      bus(1, gauge_pkg::REG_CONFIG, 32'h80);
      bus(0, gauge_pkg::REG_CONFIG, 0);
      chk(rd, 32'h0b);
      chk(lowbat, 1);
      bus(1, gauge_pkg::REG_CONFIG, 32'h08);
      bus(0, gauge_pkg::REG_TEMPERATURE, 0);
      chk(rd, itemp);
      itemp <= 8'h40;
      repeat (3) @(posedge clk);
      chk(good, 1);
      itemp <= 8'h2c;
      repeat (3) @(posedge clk);
      chk(good, 1);
      itemp <= 8'h2b;
      repeat (3) @(posedge clk);
      chk(good, 0);
      $display("config done");
   endtask
   task automatic t_flash;
      int n = 0;
      bus(1, gauge_pkg::REG_FLASH_WAIT, 32'h2);
      freq <= 1'b1;
      @(posedge clk);
      freq <= 1'b0;
      repeat (2) @(posedge clk);
      chk(irq, 1);
      while (fgo !== 1'b1 && n++ < 3000) @(posedge clk);
      chk(n / gauge_pkg::WAIT_STEP_CYCLES, 1);
      bus(1, gauge_pkg::REG_FLASH_WAIT, 0);
      freq <= 1'b1;
      @(posedge clk);
      freq <= 1'b0;
      @(posedge clk);
      chk({irq, fgo}, 2'b01);
      $display("flash done");
   endtask
   task automatic t_remove;
      bus(1, gauge_pkg::REG_CONFIG, 32'h2d);
      @(posedge clk);
      chk(good, 1);
      inserted <= 1'b0;
      while (present !== 1'b0 && cycles < 56000) @(posedge clk);
      pulse_len();
      chk({present, good}, 2'b00);
      $display("removal done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_present();
      t_irq();
      t_flash();
      t_cfg();
      t_remove();
      wrap_up();
   end
endmodule // tb
`default_nettype wire
